// File: src/dps_pkg.sv
package dps_pkg;

	// ****************************************
	// Protection states
	// ****************************************
	typedef enum logic [3:0] {
		DPS_BOOT      = 4'h1,
		DPS_OPEN      = 4'h2,
		DPS_PROTECTED = 4'h4,
		DPS_KILL      = 4'h8
	} dps_state_e;

	// Encoding of the stored / requested protection state
	localparam logic [1:0] DPS_CODE_OPEN      = 2'h0;
	localparam logic [1:0] DPS_CODE_PROTECTED = 2'h1;
	localparam logic [1:0] DPS_CODE_KILL      = 2'h2;

	// ****************************************
	// Sizes and reset values
	// ****************************************
	localparam int         DPS_ROWS      = 16;
	localparam int         DPS_ROW_W     = 4;
	localparam logic       DPS_DBG_RESET = 1'b1;
	localparam logic [1:0] DPS_ROW_UNPROT = 2'h0;

	// Row protection levels
	localparam logic DPS_LVL_UNPROT = 1'b0;
	localparam logic DPS_LVL_FULL   = 1'b1;

endpackage

// File: src/dps_row_guard.sv
`timescale 1ns/1ps
module dps_row_guard
	import dps_pkg::*;
(
	input  wire logic                 clock_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 load_i,
	input  wire logic [DPS_ROWS-1:0]  load_lvl_i,
	input  wire logic                 chip_erase_i,
	input  wire logic [DPS_ROWS-1:0]  erase_lvl_i,
	input  wire logic                 set_req_i,
	output logic                      set_rej_o,
	output logic [DPS_ROWS-1:0]       lvl_o
);

	// ****************************************
	// Row protection store
	// ****************************************
	typedef struct packed {
		logic [DPS_ROWS-1:0] lvl;
		logic                rej;
	} dps_rg_s;

	dps_rg_s st_q;
	dps_rg_s st_d;

	always_comb begin
		st_d     = st_q;
		st_d.rej = 1'b0;
		if (load_i) begin
			st_d.lvl = load_lvl_i;
		end else if (chip_erase_i) begin
			st_d.lvl = erase_lvl_i;
		end else if (set_req_i) begin
			st_d.rej = 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign lvl_o     = st_q.lvl;
	assign set_rej_o = st_q.rej;

endmodule

// File: src/dps_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - After reset sit in startup state until stored state is loaded
// - Debug port stalled until the stored state is loaded
// - Startup state forces CPU privileged
// - Unrestricted state is default; user mode may program flash and debug
// - Unrestricted plus privileged code: debugger and user accesses restricted
// - Control writes change state; unrestricted to debug-locked or permanent-lock
// - Debug-locked denies debugger memory access, keeps most register access
// - Debug-locked returns to unrestricted only after full flash erase
// - Locked states block debugger access to flash programming registers
// - Permanent lock removes debugger memory access and refuses erase
// - Permanent lock is never left
// - Each flash row is unprotected or fully protected
// - Row levels change only on the startup load and during full flash erase
// - Unprotected rows allow reads and internal writes; external writes are blocked in locked states
// - Protected rows block all writes, allow all reads
// - Debug enabled after startup; only firmware may disable it
// - Privileged entry via non-maskable interrupt held during privileged run
module dps_ctrl
	import dps_pkg::*;
(
	input  wire logic                 clock_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 sflash_valid_i,
	input  wire logic [1:0]           sflash_state_i,
	input  wire logic [DPS_ROWS-1:0]  sflash_rows_i,
	input  wire logic                 prot_wr_i,
	input  wire logic [1:0]           prot_wdata_i,
	input  wire logic                 erase_req_i,
	input  wire logic                 erase_done_i,
	input  wire logic [DPS_ROWS-1:0]  erase_rows_i,
	input  wire logic                 row_set_req_i,
	input  wire logic                 priv_req_i,
	input  wire logic                 priv_exit_i,
	input  wire logic                 cpu_user_i,
	input  wire logic                 fw_dbg_dis_i,
	input  wire logic                 dbg_req_i,
	input  wire logic                 dbg_mem_i,
	input  wire logic                 dbg_flash_reg_i,
	input  wire logic                 fl_wr_i,
	input  wire logic                 fl_ext_i,
	input  wire logic [DPS_ROW_W-1:0] fl_row_i,
	output logic [3:0]                prot_state_o,
	output logic                      dap_stall_o,
	output logic                      dbg_grant_o,
	output logic                      dbg_deny_o,
	output logic                      dbg_en_o,
	output logic                      cpu_priv_o,
	output logic                      nmi_o,
	output logic                      user_restrict_o,
	output logic                      erase_grant_o,
	output logic                      erase_refuse_o,
	output logic                      fl_wr_grant_o,
	output logic                      fl_wr_block_o,
	output logic                      row_set_rej_o,
	output logic                      prot_wr_rej_o,
	output logic [DPS_ROWS-1:0]       row_lvl_o
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		dps_state_e st;
		logic       dbg_en;
		logic       priv;
		logic       erased;
		logic       dbg_grant;
		logic       dbg_deny;
		logic       er_grant;
		logic       er_refuse;
		logic       wr_grant;
		logic       wr_block;
		logic       wr_rej;
	} dps_ctrl_s;

	dps_ctrl_s st_q;
	dps_ctrl_s st_d;

	logic [DPS_ROWS-1:0] lvl;
	logic                chip_erase;
	logic                set_rej;

	// Decoding of a stored or written state code, used twice
	function automatic dps_state_e dps_decode(input logic [1:0] code);
		case (code)
			DPS_CODE_PROTECTED: dps_decode = DPS_PROTECTED;
			DPS_CODE_KILL:      dps_decode = DPS_KILL;
			default:            dps_decode = DPS_OPEN;
		endcase
	endfunction

	// Erase completes only when not in permanent lock or startup state
	assign chip_erase = erase_done_i && (st_q.st != DPS_KILL) && (st_q.st != DPS_BOOT);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic locked;
		logic prot_row;
		st_d           = st_q;
		locked         = (st_q.st == DPS_PROTECTED) || (st_q.st == DPS_KILL);
		prot_row       = (lvl[fl_row_i] == DPS_LVL_FULL);
		st_d.dbg_grant = 1'b0;
		st_d.dbg_deny  = 1'b0;
		st_d.er_grant  = 1'b0;
		st_d.er_refuse = 1'b0;
		st_d.wr_grant  = 1'b0;
		st_d.wr_block  = 1'b0;
		st_d.wr_rej    = 1'b0;
		case (st_q.st)
			DPS_BOOT: begin
				st_d.priv = 1'b1;
				if (sflash_valid_i) begin
					st_d.st     = dps_decode(sflash_state_i);
					st_d.dbg_en = DPS_DBG_RESET;
					st_d.priv   = 1'b0;
				end
			end
			DPS_OPEN: begin
				if (prot_wr_i) begin
					if (prot_wdata_i == DPS_CODE_PROTECTED || prot_wdata_i == DPS_CODE_KILL) begin
						st_d.st = dps_decode(prot_wdata_i);
					end else if (prot_wdata_i != DPS_CODE_OPEN) begin
						st_d.wr_rej = 1'b1;
					end
				end
			end
			DPS_PROTECTED: begin
				if (chip_erase) begin
					st_d.erased = 1'b1;
				end
				if (prot_wr_i) begin
					if (prot_wdata_i == DPS_CODE_OPEN && (st_q.erased || chip_erase)) begin
						st_d.st     = DPS_OPEN;
						st_d.erased = 1'b0;
					end else if (prot_wdata_i != DPS_CODE_PROTECTED) begin
						st_d.wr_rej = 1'b1;
					end
				end
			end
			DPS_KILL: begin
				st_d.wr_rej = prot_wr_i && (prot_wdata_i != DPS_CODE_KILL);
			end
			default: begin
				st_d.st = DPS_BOOT;
			end
		endcase

		// Privilege held through NMI; only explicit exit leaves it
		if (st_q.st != DPS_BOOT) begin
			if (priv_req_i) begin
				st_d.priv = 1'b1;
			end else if (priv_exit_i) begin
				st_d.priv = 1'b0;
			end
		end

		// Firmware disable is one-way until the next reset
		if (st_q.st != DPS_BOOT && fw_dbg_dis_i && !cpu_user_i) begin
			st_d.dbg_en = 1'b0;
		end

		// Debug access decision; none while stalled
		if (dbg_req_i && st_q.st != DPS_BOOT) begin
			if (!st_q.dbg_en || st_q.priv) begin
				st_d.dbg_deny = 1'b1;
			end else if (locked && (dbg_mem_i || dbg_flash_reg_i)) begin
				st_d.dbg_deny = 1'b1;
			end else begin
				st_d.dbg_grant = 1'b1;
			end
		end

		// Erase requests
		if (erase_req_i) begin
			if (st_q.st == DPS_KILL || st_q.st == DPS_BOOT) begin
				st_d.er_refuse = 1'b1;
			end else begin
				st_d.er_grant = 1'b1;
			end
		end

		// Flash row writes
		if (fl_wr_i) begin
			if (prot_row || st_q.st == DPS_BOOT) begin
				st_d.wr_block = 1'b1;
			end else if (fl_ext_i && locked) begin
				st_d.wr_block = 1'b1;
			end else begin
				st_d.wr_grant = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q           <= '0;
			st_q.st        <= DPS_BOOT;
			st_q.dbg_en    <= DPS_DBG_RESET;
			st_q.priv      <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Row protection
	// ****************************************
	dps_row_guard u_rows (
		.clock_i      (clock_i),
		.rst_n_i      (rst_n_i),
		.load_i       (st_q.st == DPS_BOOT && sflash_valid_i),
		.load_lvl_i   (sflash_rows_i),
		.chip_erase_i (chip_erase),
		.erase_lvl_i  (erase_rows_i),
		.set_req_i    (row_set_req_i),
		.set_rej_o    (set_rej),
		.lvl_o        (lvl)
	);

	// ****************************************
	// Outputs
	// ****************************************
	assign prot_state_o    = st_q.st;
	assign dap_stall_o     = (st_q.st == DPS_BOOT);
	assign dbg_grant_o     = st_q.dbg_grant;
	assign dbg_deny_o      = st_q.dbg_deny;
	assign dbg_en_o        = st_q.dbg_en;
	assign cpu_priv_o      = st_q.priv;
	assign nmi_o           = st_q.priv;
	assign user_restrict_o = st_q.priv;
	assign erase_grant_o   = st_q.er_grant;
	assign erase_refuse_o  = st_q.er_refuse;
	assign fl_wr_grant_o   = st_q.wr_grant;
	assign fl_wr_block_o   = st_q.wr_block;
	assign row_set_rej_o   = set_rej;
	assign prot_wr_rej_o   = st_q.wr_rej;
	assign row_lvl_o       = lvl;

endmodule

// File: bench/dps_ctrl_asserts.sv
`timescale 1ns/1ps
module dps_ctrl_asserts
	import dps_pkg::*;
(
	input wire logic                clock_i,
	input wire logic                rst_n_i,
	input wire logic                prot_wr_i,
	input wire logic [1:0]          prot_wdata_i,
	input wire logic                erase_req_i,
	input wire logic                erase_done_i,
	input wire logic                row_set_req_i,
	input wire logic                dbg_req_i,
	input wire logic                dbg_mem_i,
	input wire logic                dbg_flash_reg_i,
	input wire logic [3:0]          prot_state_o,
	input wire logic                dap_stall_o,
	input wire logic                dbg_grant_o,
	input wire logic                dbg_deny_o,
	input wire logic                cpu_priv_o,
	input wire logic                nmi_o,
	input wire logic                erase_grant_o,
	input wire logic                erase_refuse_o,
	input wire logic                row_set_rej_o,
	input wire logic [DPS_ROWS-1:0] row_lvl_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	reset_boot_a: assert property ($rose(rst_n_i) |-> prot_state_o == DPS_BOOT)
		else $error("not in startup state after reset");
	boot_stall_a: assert property (prot_state_o == DPS_BOOT |-> dap_stall_o && cpu_priv_o)
		else $error("startup state without stall or privilege");
	open_lock_a: assert property (prot_state_o == DPS_OPEN && prot_wr_i
		&& prot_wdata_i == DPS_CODE_PROTECTED |=> prot_state_o == DPS_PROTECTED)
		else $error("lock write not taken");
	bad_write_a: assert property (prot_state_o == DPS_PROTECTED && prot_wr_i
		&& prot_wdata_i == DPS_CODE_KILL |=> prot_state_o == DPS_PROTECTED)
		else $error("illegal transition taken");
	kill_stays_a: assert property (prot_state_o == DPS_KILL |=> prot_state_o == DPS_KILL)
		else $error("left permanent lock");
	kill_erase_a: assert property (prot_state_o == DPS_KILL && erase_req_i
		|=> erase_refuse_o && !erase_grant_o) else $error("erase not refused");
	dbg_lock_a: assert property (dbg_req_i && (dbg_mem_i || dbg_flash_reg_i)
		&& prot_state_o inside {DPS_PROTECTED, DPS_KILL} |=> dbg_deny_o && !dbg_grant_o)
		else $error("locked debugger access granted");
	row_hold_a: assert property (row_set_req_i && !erase_done_i && prot_state_o != DPS_BOOT
		|=> row_set_rej_o && $stable(row_lvl_o)) else $error("row level changed");
	nmi_tie_a: assert property (cpu_priv_o |-> nmi_o)
		else $error("privileged without nmi");
endmodule

// File: bench/dps_dbg_model.sv
`timescale 1ns/1ps
module dps_dbg_model (
	input  wire logic clock_i,
	input  wire logic grant_i,
	input  wire logic deny_i,
	output logic      req_o,
	output logic      mem_o,
	output logic      freg_o
);
	initial begin
		req_o = 1'b0;
		mem_o = 1'b0;
		freg_o = 1'b0;
	end

	// Answer is registered on the taking edge and read just after it, none while stalled
	task automatic access(input logic mem, input logic freg, output logic [1:0] ans);
		@(posedge clock_i);
		req_o <= 1'b1;
		mem_o <= mem;
		freg_o <= freg;
		@(posedge clock_i);
		req_o <= 1'b0;
		// Flip released qualifiers so stale values are never trusted
		mem_o <= ~mem;
		freg_o <= ~freg;
		#1;
		ans = {grant_i, deny_i};
	endtask
endmodule

// File: bench/device_protection_state_control_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module device_protection_state_control_tb
	import dps_pkg::*;
;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic clock_i = 1'b0, rst_n_i = 1'b0, sflash_valid_i = 1'b0, cpu_user_i = 1'b0;
	logic fl_ext_i = 1'b0, dbg_req_i, dbg_mem_i, dbg_flash_reg_i;
	logic prot_wr_i, erase_req_i, erase_done_i, row_set_req_i, priv_req_i, priv_exit_i;
	logic fw_dbg_dis_i, fl_wr_i, dap_stall_o, dbg_grant_o, dbg_deny_o, dbg_en_o, cpu_priv_o;
	logic nmi_o, user_restrict_o, erase_grant_o, erase_refuse_o, fl_wr_grant_o, fl_wr_block_o;
	logic row_set_rej_o, prot_wr_rej_o;
	logic [1:0] sflash_state_i = DPS_CODE_OPEN, prot_wdata_i = 2'h0, ans;
	logic [DPS_ROWS-1:0] sflash_rows_i = 16'h0003, erase_rows_i = 16'h0100, row_lvl_o;
	logic [DPS_ROW_W-1:0] fl_row_i = 4'h0;
	logic [3:0] prot_state_o;
	logic [7:0] req = 8'h00;
	int num_errors = 0, n_compared = 0;
	localparam int K_FLW = 0, K_PW = 1, K_ER = 2, K_ED = 3, K_RS = 4, K_PIN = 5, K_POUT = 6;
	localparam int K_DIS = 7;

	assign {fw_dbg_dis_i, priv_exit_i, priv_req_i, row_set_req_i} = req[7:4];
	assign {erase_done_i, erase_req_i, prot_wr_i, fl_wr_i} = req[3:0];

	always #20 clock_i = ~clock_i;

	dps_ctrl DUT (.*);
	dps_dbg_model u_dbg (.clock_i(clock_i), .grant_i(dbg_grant_o), .deny_i(dbg_deny_o),
		.req_o(dbg_req_i), .mem_o(dbg_mem_i), .freg_o(dbg_flash_reg_i));

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic step(input int k, input logic [3:0] d, input logic ext);
		@(posedge clock_i);
		req <= 8'h01 << k;
		prot_wdata_i <= d[1:0];
		fl_row_i <= d;
		fl_ext_i <= ext;
		@(posedge clock_i);
		req <= 8'h00;
		#1;
	endtask

	task automatic complete_run;
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (20) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		#1;
		`CHK(prot_state_o, DPS_BOOT)
		`CHK({dap_stall_o, cpu_priv_o}, 2'h3)
		u_dbg.access(1'b1, 1'b0, ans);
		`CHK(ans, 2'h0)
		@(posedge clock_i);
		sflash_valid_i <= 1'b1;
		cpu_user_i <= 1'b1;
		@(posedge clock_i);
		sflash_valid_i <= 1'b0;
		#1;
		`CHK(prot_state_o, DPS_OPEN)
		`CHK({row_lvl_o, dbg_en_o, cpu_priv_o}, {16'h0003, 2'h2})
		u_dbg.access(1'b1, 1'b0, ans);
		`CHK(ans, 2'h2)
		for (int i = 0; i < 4; i++) begin
			step(K_FLW, i[1] ? 4'h5 : 4'h1, i[0]);
			`CHK({fl_wr_grant_o, fl_wr_block_o}, i[1] ? 2'h2 : 2'h1)
		end
		step(K_RS, 4'h0, 1'b0);
		`CHK({row_set_rej_o, row_lvl_o}, {1'b1, 16'h0003})
		step(K_DIS, 4'h0, 1'b0);
		`CHK(dbg_en_o, 1'b1)
		step(K_PIN, 4'h0, 1'b0);
		`CHK({cpu_priv_o, nmi_o, user_restrict_o}, 3'h7)
		u_dbg.access(1'b1, 1'b0, ans);
		`CHK(ans, 2'h1)
		step(K_POUT, 4'h0, 1'b0);
		`CHK({cpu_priv_o, nmi_o}, 2'h0)
		step(K_PW, 4'h1, 1'b0);
		`CHK(prot_state_o, DPS_PROTECTED)
		u_dbg.access(1'b1, 1'b0, ans);
		`CHK(ans, 2'h1)
		u_dbg.access(1'b0, 1'b1, ans);
		`CHK(ans, 2'h1)
		u_dbg.access(1'b0, 1'b0, ans);
		`CHK(ans, 2'h2)
		step(K_PW, 4'h2, 1'b0);
		`CHK(prot_state_o, DPS_PROTECTED)
		`CHK(prot_wr_rej_o, 1'b1)
		step(K_PW, 4'h0, 1'b0);
		`CHK(prot_state_o, DPS_PROTECTED)
		step(K_ER, 4'h0, 1'b0);
		`CHK(erase_grant_o, 1'b1)
		step(K_ED, 4'h0, 1'b0);
		`CHK(row_lvl_o, 16'h0100)
		step(K_PW, 4'h0, 1'b0);
		`CHK(prot_state_o, DPS_OPEN)
		step(K_PW, 4'h2, 1'b0);
		`CHK(prot_state_o, DPS_KILL)
		step(K_ER, 4'h0, 1'b0);
		`CHK({erase_grant_o, erase_refuse_o}, 2'h1)
		step(K_ED, 4'h0, 1'b0);
		step(K_PW, 4'h0, 1'b0);
		`CHK(prot_state_o, DPS_KILL)
		u_dbg.access(1'b1, 1'b0, ans);
		`CHK(ans, 2'h1)
		step(K_PIN, 4'h0, 1'b0);
		// Disable only counts from firmware, so leave user mode first
		cpu_user_i <= 1'b0;
		step(K_DIS, 4'h0, 1'b0);
		step(K_POUT, 4'h0, 1'b0);
		`CHK(dbg_en_o, 1'b0)
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		@(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		#1;
		`CHK(prot_state_o, DPS_BOOT)
		`CHK(dbg_en_o, 1'b1)
		complete_run();
	end

	// Whole sequence needs about 80 cycles
	initial begin
		#40000;
		num_errors++;
		complete_run();
	end
endmodule

bind dps_ctrl dps_ctrl_asserts u_chk (.*);
